// [hdl/pcie_cap2_aer_status_regs.sv]
// Purpose: second-generation device, link and slot capability registers
//          and the error reporting header and uncorrectable status
// Assumes: link engines pulse error events for one pclk cycle
// Notes:   sticky fields reset only on sticky_rstn
//
// What this block does
// [R01] latency tolerance support reads one
// [R02] buffer flush/fill support reads 01b
// [R03] latency tolerance enable, writable, resets zero
// [R04] flush/fill enable field writable, resets 00b
// [R05] de-emphasis select follows port direction
// [R06] current de-emphasis follows port direction
// [R07] second slot capabilities read all zero
// [R08] capability id reads 0001h
// [R09] capability version reads 1h
// [R10] next capability pointer reads 140h
// [R11] training error sets sticky status bit 0
// [R12] link protocol error sets bit 4
// [R13] poisoned packet sets bit 12
// [R14] flow control error sets bit 13
// [R15] completion timeout sets bit 14
// [R16] completer abort sets bit 15
// [R17] unexpected completion sets bit 16
// [R18] receiver overflow sets bit 17
// [R19] malformed packet sets bit 18
// [R20] end-to-end crc error sets bit 19
// [R21] unsupported request sets bit 20
// [R22] access control violation sets bit 21
// [R23] reserved reads zero, write one clears
// [R24] masked errors are not reported
`timescale 1ns/1ps
module pcie_cap2_aer_status_regs import cfg_regs_pkg::*; #(
   parameter bit DOWNSTREAM_PORT = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sticky_rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic evt_training_error,
   input wire logic evt_link_protocol_error,
   input wire logic evt_poisoned_packet,
   input wire logic evt_flow_control_error,
   input wire logic evt_completion_timeout,
   input wire logic evt_completer_abort,
   input wire logic evt_unexpected_completion,
   input wire logic evt_receiver_overflow,
   input wire logic evt_malformed_packet,
   input wire logic evt_end_to_end_crc,
   input wire logic evt_unsupported_request,
   input wire logic evt_access_violation,
   output logic latency_report_enable,
   output logic [1:0] buffer_flush_enable,
   output logic [3:0] target_link_speed,
   output logic enter_compliance,
   output logic hardware_speed_change_disable,
   output logic [2:0] transmit_margin,
   output logic enter_modified_compliance,
   output logic compliance_skip_sets,
   output logic compliance_deemphasis,
   output logic deemphasis_select,
   output logic error_report,
   output logic [31:0] error_report_bits
);
   // ****************************************************
   // address decode
   // ****************************************************
   logic hit_dev_caps;
   logic hit_dev_ctrl;
   logic hit_link_caps;
   logic hit_link_ctrl;
   logic hit_slot_caps;
   logic hit_slot_ctrl;
   logic hit_aer_hdr;
   logic hit_uncor_stat;
   logic hit_uncor_mask;
   logic addr_ok;
   logic wr_fire;

   // one word per register, low two address bits ignored
   assign hit_dev_caps = word_hit(paddr, OFS_DEV_CAPS2);
   assign hit_dev_ctrl = word_hit(paddr, OFS_DEV_CTRL2);
   assign hit_link_caps = word_hit(paddr, OFS_LINK_CAPS2);
   assign hit_link_ctrl = word_hit(paddr, OFS_LINK_CTRL2);
   assign hit_slot_caps = word_hit(paddr, OFS_SLOT_CAPS2);
   assign hit_slot_ctrl = word_hit(paddr, OFS_SLOT_CTRL2);
   assign hit_aer_hdr = word_hit(paddr, OFS_AER_HDR);
   assign hit_uncor_stat = word_hit(paddr, OFS_UNCOR_STAT);
   assign hit_uncor_mask = word_hit(paddr, OFS_UNCOR_MASK);

   // any mapped word; others answer with an error
   assign addr_ok = hit_dev_caps | hit_dev_ctrl | hit_link_caps |
                    hit_link_ctrl | hit_slot_caps | hit_slot_ctrl |
                    hit_aer_hdr | hit_uncor_stat | hit_uncor_mask;

   // ****************************************************
   // write strobes
   // ****************************************************
   logic wr_dev_ctrl;
   logic wr_link_ctrl;
   logic wr_uncor_stat;
   logic wr_uncor_mask;

   // a write lands only at the edge that completes it
   assign wr_dev_ctrl = wr_fire & hit_dev_ctrl;
   assign wr_link_ctrl = wr_fire & hit_link_ctrl;
   assign wr_uncor_stat = wr_fire & hit_uncor_stat;
   assign wr_uncor_mask = wr_fire & hit_uncor_mask;

   // ****************************************************
   // device control and hardware speed change disable, ordinary reset
   // ****************************************************
   logic ltr_en_reg;
   logic ltr_en_next;
   logic [1:0] obff_en_reg;
   logic [1:0] obff_en_next;
   logic hwsc_dis_reg;
   logic hwsc_dis_next;

   // writable fields take the written bits, others hold
   assign ltr_en_next = wr_dev_ctrl ?
                        pwdata[LTR_EN_BIT] : ltr_en_reg; // [R03]
   assign obff_en_next = wr_dev_ctrl ?
                         pwdata[OBFF_EN_LSB +: 2] : obff_en_reg; // [R04]
   assign hwsc_dis_next = wr_link_ctrl ?
                          pwdata[HWSC_DIS_BIT] : hwsc_dis_reg;

   // fields cleared by ordinary reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ltr_en_reg <= 1'b0; // [R03]
         obff_en_reg <= OBFF_EN_RST; // [R04]
         hwsc_dis_reg <= 1'b0;
      end else begin
         ltr_en_reg <= ltr_en_next;
         obff_en_reg <= obff_en_next;
         hwsc_dis_reg <= hwsc_dis_next;
      end
   end

   // ****************************************************
   // link control, sticky reset
   // ****************************************************
   logic [3:0] speed_reg;
   logic [3:0] speed_next;
   logic compl_reg;
   logic compl_next;
   logic [2:0] margin_reg;
   logic [2:0] margin_next;
   logic mod_compl_reg;
   logic mod_compl_next;
   logic compl_sos_reg;
   logic compl_sos_next;
   logic compl_deemp_reg;
   logic compl_deemp_next;

   // sticky link fields follow software writes
   assign speed_next = wr_link_ctrl ?
                       pwdata[SPEED_LSB +: 4] : speed_reg;
   assign compl_next = wr_link_ctrl ? pwdata[COMPL_BIT] : compl_reg;
   assign margin_next = wr_link_ctrl ?
                        pwdata[MARGIN_LSB +: 3] : margin_reg;
   assign mod_compl_next = wr_link_ctrl ?
                           pwdata[MOD_COMPL_BIT] : mod_compl_reg;
   assign compl_sos_next = wr_link_ctrl ?
                           pwdata[COMPL_SOS_BIT] : compl_sos_reg;
   assign compl_deemp_next = wr_link_ctrl ?
                             pwdata[COMPL_DEEMP_BIT] : compl_deemp_reg;

   // survive ordinary reset, loaded with their reset values by sticky reset only
   always_ff @(posedge pclk or negedge sticky_rstn) begin
      if (!sticky_rstn) begin
         speed_reg <= SPEED_RST;
         compl_reg <= 1'b0;
         margin_reg <= MARGIN_RST;
         mod_compl_reg <= 1'b0;
         compl_sos_reg <= 1'b0;
         compl_deemp_reg <= 1'b0;
      end else begin
         speed_reg <= speed_next;
         compl_reg <= compl_next;
         margin_reg <= margin_next;
         mod_compl_reg <= mod_compl_next;
         compl_sos_reg <= compl_sos_next;
         compl_deemp_reg <= compl_deemp_next;
      end
   end

   // ****************************************************
   // de-emphasis, fixed by port direction
   // ****************************************************
   logic deemp_reg;

   // read-only, reset value set by the port direction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deemp_reg <= DOWNSTREAM_PORT; // [R05] [R06]
      end else begin
         deemp_reg <= deemp_reg;
      end
   end

   // ****************************************************
   // uncorrectable error mask, sticky
   // ****************************************************
   logic [31:0] mask_reg;
   logic [31:0] mask_next;

   // only implemented error bits can be masked
   assign mask_next = wr_uncor_mask ? (pwdata & UNCOR_IMPL) : mask_reg;

   // mask holds across ordinary reset
   always_ff @(posedge pclk or negedge sticky_rstn) begin
      if (!sticky_rstn) begin
         mask_reg <= 32'h0000_0000;
      end else begin
         mask_reg <= mask_next; // [R24]
      end
   end

   // ****************************************************
   // uncorrectable error status
   // ****************************************************
   logic [31:0] err_evt;
   logic [31:0] err_clr;
   logic [31:0] err_stat;

   // link engine events placed on their status bits
   always_comb begin
      err_evt = 32'h0000_0000;
      err_evt[0] = evt_training_error; // [R11]
      err_evt[4] = evt_link_protocol_error; // [R12]
      err_evt[12] = evt_poisoned_packet; // [R13]
      err_evt[13] = evt_flow_control_error; // [R14]
      err_evt[14] = evt_completion_timeout; // [R15]
      err_evt[15] = evt_completer_abort; // [R16]
      err_evt[16] = evt_unexpected_completion; // [R17]
      err_evt[17] = evt_receiver_overflow; // [R18]
      err_evt[18] = evt_malformed_packet; // [R19]
      err_evt[19] = evt_end_to_end_crc; // [R20]
      err_evt[20] = evt_unsupported_request; // [R21]
      err_evt[21] = evt_access_violation; // [R22]
   end

   // writing one clears, writing zero leaves the bit
   assign err_clr = wr_uncor_stat ? pwdata : 32'h0000_0000; // [R23]

   // sticky write-one-to-clear status and masked report
   error_status_log #(
      .WIDTH(32),
      .IMPL(UNCOR_IMPL)
   ) u_err_log (
      .pclk(pclk),
      .sticky_rstn(sticky_rstn),
      .event_in(err_evt),
      .clear_in(err_clr),
      .mask_in(mask_reg),
      .status(err_stat),
      .report(error_report),
      .report_bits(error_report_bits)
   );

   // ****************************************************
   // read data assembly
   // ****************************************************
   logic [31:0] dev_caps_word;
   logic [31:0] dev_ctrl_word;
   logic [31:0] link_ctrl_word;
   logic [31:0] aer_hdr_word;
   logic [31:0] rdata_mux;

   // capability words, unlisted bits read zero
   always_comb begin
      dev_caps_word = 32'h0000_0000;
      dev_caps_word[LTR_SUP_BIT] = 1'b1; // [R01]
      dev_caps_word[OBFF_SUP_LSB +: 2] = OBFF_SUP_VAL; // [R02]
   end

   // device control low half, device status high half zero
   always_comb begin
      dev_ctrl_word = 32'h0000_0000;
      dev_ctrl_word[LTR_EN_BIT] = ltr_en_reg; // [R03]
      dev_ctrl_word[OBFF_EN_LSB +: 2] = obff_en_reg; // [R04]
   end

   // link control low half, link status high half
   always_comb begin
      link_ctrl_word = 32'h0000_0000;
      link_ctrl_word[SPEED_LSB +: 4] = speed_reg;
      link_ctrl_word[COMPL_BIT] = compl_reg;
      link_ctrl_word[HWSC_DIS_BIT] = hwsc_dis_reg;
      link_ctrl_word[DEEMP_SEL_BIT] = deemp_reg; // [R05]
      link_ctrl_word[MARGIN_LSB +: 3] = margin_reg;
      link_ctrl_word[MOD_COMPL_BIT] = mod_compl_reg;
      link_ctrl_word[COMPL_SOS_BIT] = compl_sos_reg;
      link_ctrl_word[COMPL_DEEMP_BIT] = compl_deemp_reg;
      link_ctrl_word[CUR_DEEMP_BIT] = deemp_reg; // [R06]
   end

   // error reporting capability header
   always_comb begin
      aer_hdr_word = 32'h0000_0000;
      aer_hdr_word[15:0] = AER_CAP_ID; // [R08]
      aer_hdr_word[CAP_VER_LSB +: 4] = AER_CAP_VER; // [R09]
      aer_hdr_word[NEXT_PTR_LSB +: 12] = AER_NEXT_PTR; // [R10]
   end

   // select by decoded word, zero words need no term
   assign rdata_mux =
      ({32{hit_dev_caps}} & dev_caps_word) |
      ({32{hit_dev_ctrl}} & dev_ctrl_word) |
      ({32{hit_link_ctrl}} & link_ctrl_word) |
      ({32{hit_aer_hdr}} & aer_hdr_word) |
      ({32{hit_uncor_stat}} & err_stat) |
      ({32{hit_uncor_mask}} & mask_reg); // [R07] [R23]

   // ****************************************************
   // bus answer
   // ****************************************************
   apb_answer u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .addr_ok(addr_ok),
      .rdata_in(rdata_mux),
      .pready(pready),
      .pslverr(pslverr),
      .prdata(prdata),
      .wr_fire(wr_fire)
   );

   // ****************************************************
   // control outputs, straight from the flops
   // ****************************************************
   assign latency_report_enable = ltr_en_reg; // [R03]
   assign buffer_flush_enable = obff_en_reg; // [R04]
   assign target_link_speed = speed_reg;
   assign enter_compliance = compl_reg;
   assign hardware_speed_change_disable = hwsc_dis_reg;
   assign transmit_margin = margin_reg;
   assign enter_modified_compliance = mod_compl_reg;
   assign compliance_skip_sets = compl_sos_reg;
   assign compliance_deemphasis = compl_deemp_reg;
   assign deemphasis_select = deemp_reg; // [R05]
endmodule // pcie_cap2_aer_status_regs

// [hdl/cfg_regs_pkg.sv]
// Purpose: shared offsets, fields and reset values for the port
//          second-generation capability and error reporting registers
// Assumes: 32-bit apb data, 12-bit configuration byte address
// Notes:   each register holds one aligned word
package cfg_regs_pkg;
   // ****************************************************
   // register offsets
   // ****************************************************
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_DEV_CAPS2 = 12'h0e4;
   localparam logic [11:0] OFS_DEV_CTRL2 = 12'h0e8;
   localparam logic [11:0] OFS_LINK_CAPS2 = 12'h0ec;
   localparam logic [11:0] OFS_LINK_CTRL2 = 12'h0f0;
   localparam logic [11:0] OFS_SLOT_CAPS2 = 12'h0f4;
   localparam logic [11:0] OFS_SLOT_CTRL2 = 12'h0f8;
   localparam logic [11:0] OFS_AER_HDR = 12'h100;
   localparam logic [11:0] OFS_UNCOR_STAT = 12'h104;
   localparam logic [11:0] OFS_UNCOR_MASK = 12'h108;
   // ****************************************************
   // field positions
   // ****************************************************
   localparam int LTR_SUP_BIT = 11;
   localparam int OBFF_SUP_LSB = 18;
   localparam int LTR_EN_BIT = 10;
   localparam int OBFF_EN_LSB = 13;
   localparam int SPEED_LSB = 0;
   localparam int COMPL_BIT = 4;
   localparam int HWSC_DIS_BIT = 5;
   localparam int DEEMP_SEL_BIT = 6;
   localparam int MARGIN_LSB = 7;
   localparam int MOD_COMPL_BIT = 10;
   localparam int COMPL_SOS_BIT = 11;
   localparam int COMPL_DEEMP_BIT = 12;
   localparam int CUR_DEEMP_BIT = 16;
   localparam int CAP_VER_LSB = 16;
   localparam int NEXT_PTR_LSB = 20;
   // ****************************************************
   // constant and reset values
   // ****************************************************
   localparam logic [1:0] OBFF_SUP_VAL = 2'h1;
   localparam logic [1:0] OBFF_EN_RST = 2'h0;
   localparam logic [3:0] SPEED_RST = 4'h2;
   localparam logic [2:0] MARGIN_RST = 3'h0;
   localparam logic [15:0] AER_CAP_ID = 16'h0001;
   localparam logic [3:0] AER_CAP_VER = 4'h1;
   localparam logic [11:0] AER_NEXT_PTR = 12'h140;
   // implemented uncorrectable error bits (0, 4, 12..21)
   localparam logic [31:0] UNCOR_IMPL = 32'h003f_f011;
   // ****************************************************
   // apb answer phase
   // ****************************************************
   typedef enum logic {PH_IDLE, PH_ANSWER} apb_phase_e;
   // word decode shared by read and write paths
   function automatic logic word_hit(input logic [11:0] addr,
                                     input logic [11:0] ofs);
      word_hit = (addr[11:2] == ofs[11:2]);
   endfunction
endpackage

// [hdl/apb_answer.sv]
// Purpose: apb handshake, one wait state, registered answer
// Assumes: master holds the request until pready is sampled high
// Notes:   wr_fire marks the completing edge of a write
`timescale 1ns/1ps
module apb_answer import cfg_regs_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic addr_ok,
   input wire logic [31:0] rdata_in,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   output logic wr_fire
);
   apb_phase_e phase_reg;
   logic take;
   // access phase seen and not yet answered
   assign take = psel & penable & (phase_reg == PH_IDLE);
   assign wr_fire = psel & penable & pwrite & (phase_reg == PH_ANSWER)
                    & addr_ok;
   assign pready = (phase_reg == PH_ANSWER);
   // answer register, cleared at the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= PH_IDLE;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         case (phase_reg)
            PH_IDLE: begin
               if (take) begin
                  phase_reg <= PH_ANSWER;
                  pslverr <= ~addr_ok; // [R23]
                  prdata <= (pwrite | ~addr_ok) ? 32'h0000_0000 : rdata_in;
               end
            end
            PH_ANSWER: begin
               phase_reg <= PH_IDLE;
               pslverr <= 1'b0;
               prdata <= 32'h0000_0000;
            end
            default: phase_reg <= PH_IDLE;
         endcase
      end
   end
endmodule // apb_answer

// [hdl/error_status_log.sv]
// Purpose: sticky write-one-to-clear error status with masked reporting
// Assumes: events are one-cycle pulses in the pclk domain
// Notes:   a set in the clearing cycle wins
`timescale 1ns/1ps
module error_status_log #(
   parameter int WIDTH = 32,
   parameter logic [WIDTH-1:0] IMPL = '1
) (
   input wire logic pclk,
   input wire logic sticky_rstn,
   input wire logic [WIDTH-1:0] event_in,
   input wire logic [WIDTH-1:0] clear_in,
   input wire logic [WIDTH-1:0] mask_in,
   output logic [WIDTH-1:0] status,
   output logic report,
   output logic [WIDTH-1:0] report_bits
);
   logic [WIDTH-1:0] hit;
   logic [WIDTH-1:0] status_next;
   // set wins over clear, unimplemented bits stay zero
   assign hit = event_in & IMPL;
   assign status_next = (status & ~clear_in) | hit;
   // masked events are logged in status but not reported [R24]
   always_ff @(posedge pclk or negedge sticky_rstn) begin
      if (!sticky_rstn) begin
         status <= '0;
         report <= 1'b0;
         report_bits <= '0;
      end else begin
         status <= status_next & IMPL;
         report <= |(hit & ~mask_in); // [R24]
         report_bits <= hit & ~mask_in; // [R24]
      end
   end
endmodule // error_status_log

// [bench/cap2_regs_assertions.sv]
// Purpose: port-level checks of the capability and error status bank
// Assumes: single pclk domain, bench holds apb requests until pready
// Notes:   bound to the register bank, watches its ports only
`timescale 1ns/1ps
module cap2_regs_checker #(
   parameter bit DOWNSTREAM_PORT = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sticky_rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic evt_training_error,
   input wire logic evt_link_protocol_error,
   input wire logic evt_poisoned_packet,
   input wire logic evt_flow_control_error,
   input wire logic evt_completion_timeout,
   input wire logic evt_completer_abort,
   input wire logic evt_unexpected_completion,
   input wire logic evt_receiver_overflow,
   input wire logic evt_malformed_packet,
   input wire logic evt_end_to_end_crc,
   input wire logic evt_unsupported_request,
   input wire logic evt_access_violation,
   input wire logic latency_report_enable,
   input wire logic [1:0] buffer_flush_enable,
   input wire logic deemphasis_select,
   input wire logic error_report,
   input wire logic [31:0] error_report_bits
);
   // ****************************************************
   // event vector in status bit order
   // ****************************************************
   wire logic [31:0] evt_vec;
   wire logic wr_ctrl;
   assign evt_vec = {10'h0, evt_access_violation, evt_unsupported_request,
      evt_end_to_end_crc, evt_malformed_packet, evt_receiver_overflow,
      evt_unexpected_completion, evt_completer_abort,
      evt_completion_timeout, evt_flow_control_error, evt_poisoned_packet,
      7'h0, evt_link_protocol_error, 3'h0, evt_training_error};
   assign wr_ctrl = psel && penable && pready && pwrite
      && (paddr[11:2] == 10'h03a);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !sticky_rstn);
   // ****************************************************
   // assertions
   // ****************************************************
   a_ready_one_wait: assert property ((psel && !penable) ##1 (psel && penable)
      |-> !pready ##1 pready) else $error("answer not after one wait");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("slave error outside answer");
   a_ltr_written: assert property (wr_ctrl |=> latency_report_enable ==
      $past(pwdata[10])) else $error("latency enable not written");
   a_flush_written: assert property (wr_ctrl |=> buffer_flush_enable ==
      $past(pwdata[14:13])) else $error("flush enable not written");
   a_ctrl_reset: assert property (disable iff (!sticky_rstn) !presetn |->
      !latency_report_enable && buffer_flush_enable == 2'h0)
      else $error("control reset value wrong");
   a_deemp_fixed: assert property (deemphasis_select == DOWNSTREAM_PORT)
      else $error("de-emphasis select wrong");
   a_report_cause: assert property (error_report |-> error_report_bits != 0
      && (error_report_bits & ~$past(evt_vec)) == 32'h0)
      else $error("report without matching event");
   a_report_mapped: assert property (error_report_bits != 0 |->
      (error_report_bits & ~32'h003f_f011) == 32'h0 && error_report)
      else $error("report outside implemented bits");
   // main scenarios reached
   c_write: cover property (wr_ctrl);
   c_err: cover property (pslverr);
   c_report: cover property (error_report);
endmodule // cap2_regs_checker

bind pcie_cap2_aer_status_regs cap2_regs_checker #(
   .DOWNSTREAM_PORT(DOWNSTREAM_PORT)) u_chk (.pclk(pclk), .presetn(presetn),
   .sticky_rstn(sticky_rstn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr),
   .evt_training_error(evt_training_error),
   .evt_link_protocol_error(evt_link_protocol_error),
   .evt_poisoned_packet(evt_poisoned_packet),
   .evt_flow_control_error(evt_flow_control_error),
   .evt_completion_timeout(evt_completion_timeout),
   .evt_completer_abort(evt_completer_abort),
   .evt_unexpected_completion(evt_unexpected_completion),
   .evt_receiver_overflow(evt_receiver_overflow),
   .evt_malformed_packet(evt_malformed_packet),
   .evt_end_to_end_crc(evt_end_to_end_crc),
   .evt_unsupported_request(evt_unsupported_request),
   .evt_access_violation(evt_access_violation),
   .latency_report_enable(latency_report_enable),
   .buffer_flush_enable(buffer_flush_enable),
   .deemphasis_select(deemphasis_select), .error_report(error_report),
   .error_report_bits(error_report_bits));

// [bench/pcie_cap2_aer_status_regs_tb_top.sv]
// Purpose: apb-driven tests of the capability and error status bank
// Assumes: downstream port instance, one wait state answers
// Notes:   events are pulsed one cycle each
`timescale 1ns/1ps
module pcie_cap2_aer_status_regs_tb_top;
   // ****************************************************
   // signals and design
   // ****************************************************
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic sticky_rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [11:0] evt = 12'h0;
   logic pready, pslverr, error_report, ltr_en, hwsc_dis;
   logic [31:0] prdata, error_report_bits;
   logic [1:0] flush_en;
   logic [3:0] speed;
   int errors = 0;
   int cmp_count = 0;
   int pos[12] = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};
   pcie_cap2_aer_status_regs #(.DOWNSTREAM_PORT(1'b1)) dut (.pclk(pclk),
      .presetn(presetn), .sticky_rstn(sticky_rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .evt_training_error(evt[0]), .evt_link_protocol_error(evt[1]),
      .evt_poisoned_packet(evt[2]), .evt_flow_control_error(evt[3]),
      .evt_completion_timeout(evt[4]), .evt_completer_abort(evt[5]),
      .evt_unexpected_completion(evt[6]), .evt_receiver_overflow(evt[7]),
      .evt_malformed_packet(evt[8]), .evt_end_to_end_crc(evt[9]),
      .evt_unsupported_request(evt[10]), .evt_access_violation(evt[11]),
      .latency_report_enable(ltr_en), .buffer_flush_enable(flush_en),
      .target_link_speed(speed), .enter_compliance(),
      .hardware_speed_change_disable(hwsc_dis), .transmit_margin(),
      .enter_modified_compliance(), .compliance_skip_sets(),
      .compliance_deemphasis(), .deemphasis_select(),
      .error_report(error_report), .error_report_bits(error_report_bits));
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   // ****************************************************
   // tasks
   // ****************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic exp_err, input logic [31:0] exp);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk({30'h0, pready, pslverr}, {31'h1, exp_err});
      if (!w) chk(prdata, exp);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse(input int i, input logic rep);
      @(posedge pclk);
      evt <= 12'h1 << i;
      @(posedge pclk);
      evt <= 12'h0;
      #1;
      chk({31'h0, error_report}, {31'h0, rep});
      chk(error_report_bits, rep ? 32'h1 << pos[i] : 32'h0);
   endtask
   task automatic soft_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ****************************************************
   // tests
   // ****************************************************
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      sticky_rstn <= 1'b1;
      apb(1, 12'h0e4, 32'hffff_ffff, 0, 0);
      apb(0, 12'h0e4, 0, 0, 32'h0004_0800);
      apb(0, 12'h0e8, 0, 0, 32'h0);
      apb(0, 12'h0f0, 0, 0, 32'h0001_0042);
      apb(1, 12'h0f4, 32'hffff_ffff, 0, 0);
      apb(0, 12'h0f4, 0, 0, 32'h0);
      apb(1, 12'h100, 32'hffff_ffff, 0, 0);
      apb(0, 12'h100, 0, 0, 32'h1401_0001);
      apb(0, 12'h200, 0, 1, 32'h0);
      $display("test reset values done");
      apb(1, 12'h0e8, 32'hffff_ffff, 0, 0);
      apb(0, 12'h0e8, 0, 0, 32'h0000_6400);
      chk({29'h0, ltr_en, flush_en}, 32'h7);
      apb(1, 12'h0f0, 32'hffff_ffff, 0, 0);
      apb(0, 12'h0f0, 0, 0, 32'h0001_1fff);
      soft_reset();
      chk({27'h0, hwsc_dis, speed}, 32'hf);
      apb(0, 12'h0e8, 0, 0, 32'h0);
      $display("test control writes done");
      apb(1, 12'h104, 32'hffff_ffff, 0, 0);
      apb(0, 12'h104, 0, 0, 32'h0);
      for (int i = 0; i < 12; i++) begin
         pulse(i, 1'b1);
      end
      apb(0, 12'h104, 0, 0, 32'h003f_f011);
      apb(1, 12'h104, 32'h0000_1010, 0, 0);
      apb(0, 12'h104, 0, 0, 32'h003f_e001);
      $display("test error status done");
      apb(1, 12'h104, 32'hffff_ffff, 0, 0);
      apb(1, 12'h108, 32'hffff_ffff, 0, 0);
      apb(0, 12'h108, 0, 0, 32'h003f_f011);
      pulse(0, 1'b0);
      soft_reset();
      apb(0, 12'h104, 0, 0, 32'h0000_0001);
      $display("test masking done");
      stop_test();
   end
   // watchdog: far longer than the tests need
   initial begin
      #(20000 * 5);
      errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      stop_test();
   end
endmodule // pcie_cap2_aer_status_regs_tb_top
